//--- rtl/ocl_top.sv
// Write-once option latches and oscillator option byte behind an Avalon-MM slave
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
module ocl_top
(
  // Clock and resets
  input  wire logic                      clock,
  input  wire logic                      rstn,
  input  wire logic                      por_rstn,
  // Avalon-MM slave
  input  wire logic [ocl_pkg::ADDR_W-1:0] address,
  input  wire logic                      read,
  input  wire logic                      write,
  input  wire logic [ocl_pkg::DATA_W-1:0] writedata,
  input  wire logic [3:0]                byteenable,
  output logic      [ocl_pkg::DATA_W-1:0] readdata,
  output logic                           waitrequest,
  // Non-volatile array and system controller
  input  wire logic [7:0]                nv_option_byte,
  input  wire logic                      stop_exit_by_reset,
  // Option outputs
  output ocl_pkg::ocl_cfg_t              cfg
);

  // Two structs: trip bits and option byte must outlive ordinary resets
  ocl_pkg::ocl_state_t     s_reg;
  ocl_pkg::ocl_state_t     s_next;
  ocl_pkg::ocl_por_state_t p_reg;
  ocl_pkg::ocl_por_state_t p_next;
  logic                    req;
  logic                    hit_a;
  logic                    hit_b;
  logic                    hit_o;

  function automatic logic addr_hit(input logic [7:0] a, input logic [5:0] idx);
    addr_hit = (a == {idx, 2'h0});
  endfunction

  function automatic logic [7:0] latch_b_view(input ocl_pkg::ocl_state_t s, input ocl_pkg::ocl_por_state_t p);
    logic [7:0] v;
    v = s.latch_b;
    v[ocl_pkg::BIT_TRIP_HI] = p.trip[1];
    v[ocl_pkg::BIT_TRIP_LO] = p.trip[0];
    latch_b_view = v;
  endfunction

  assign req         = read | write;
  assign hit_a       = addr_hit(address, ocl_pkg::IDX_LATCH_A);
  assign hit_b       = addr_hit(address, ocl_pkg::IDX_LATCH_B);
  assign hit_o       = addr_hit(address, ocl_pkg::IDX_OSC_OPT);
  // One wait cycle on every access, then the answer
  assign waitrequest = req & ~s_reg.ack;
  assign readdata    = {24'h000000, s_reg.rdata};

  always_comb
  begin
    s_next     = s_reg;
    p_next     = p_reg;
    s_next.ack = req & ~s_reg.ack;
    if (!p_reg.osc_loaded)
    begin
      p_next.osc_byte   = nv_option_byte; // RULE16
      p_next.osc_loaded = 1'b1;
    end
    if (read && !s_reg.ack)
    begin
      if (hit_a)
        s_next.rdata = s_reg.latch_a; // RULE3
      else if (hit_b)
        s_next.rdata = latch_b_view(s_reg, p_reg); // RULE3
      else if (hit_o)
        s_next.rdata = p_reg.osc_byte;
      else
        s_next.rdata = 8'h00;
    end
    // Write lands on the edge where waitrequest is low
    if (write && s_reg.ack && byteenable[0])
    begin
      if (hit_a && !s_reg.written_a) // RULE1 RULE20
      begin
        s_next.latch_a   = writedata[7:0] & ocl_pkg::MASK_LATCH_A;
        s_next.written_a = 1'b1;
      end
      if (hit_b && !s_reg.written_b) // RULE1 RULE20
      begin
        s_next.latch_b   = writedata[7:0] & ocl_pkg::MASK_LATCH_B;
        s_next.written_b = 1'b1;
        if (!p_reg.trip_written) // RULE4
        begin
          p_next.trip         = writedata[ocl_pkg::BIT_TRIP_HI:ocl_pkg::BIT_TRIP_LO];
          p_next.trip_written = 1'b1;
        end
      end
      // Option byte ignores bus writes; only the reload from nv_option_byte after power-on reset alters it
      // RULE17
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      s_reg.ack       <= 1'b0;
      s_reg.rdata     <= 8'h00;
      s_reg.latch_a   <= ocl_pkg::RST_LATCH; // RULE2
      s_reg.latch_b   <= ocl_pkg::RST_LATCH; // RULE2
      s_reg.written_a <= 1'b0;
      s_reg.written_b <= 1'b0;
    end
    else
      s_reg <= s_next;
  end

  always_ff @(posedge clock or negedge por_rstn)
  begin
    if (!por_rstn)
    begin
      p_reg.trip         <= ocl_pkg::RST_TRIP; // RULE5
      p_reg.trip_written <= 1'b0;
      p_reg.osc_byte     <= ocl_pkg::ERASED_BYTE;
      p_reg.osc_loaded   <= 1'b0;
    end
    else
      p_reg <= p_next;
  end

  always_comb
  begin
    cfg.watchdog_enable          = ~s_reg.latch_a[ocl_pkg::BIT_WDG_DIS]; // RULE12
    cfg.watchdog_timeout_cycles  = s_reg.latch_a[ocl_pkg::BIT_WDG_RATE] ?
                                   ocl_pkg::WDG_SHORT_CYC : ocl_pkg::WDG_LONG_CYC; // RULE6
    cfg.brownout_enable          = ~s_reg.latch_a[ocl_pkg::BIT_BO_DIS]; // RULE7
    cfg.brownout_trip_sel        = p_reg.trip; // RULE5
    // Reset exit forces the long delay
    cfg.stop_recovery_cycles     = (s_reg.latch_a[ocl_pkg::BIT_SHORT_STOP_RECOVERY] && !stop_exit_by_reset) ?
                                   ocl_pkg::REC_SHORT_CYC : ocl_pkg::REC_LONG_CYC; // RULE8 RULE9
    cfg.stop_instr_enable        = s_reg.latch_a[ocl_pkg::BIT_STOP_EN]; // RULE11
    cfg.stop_opcode_illegal      = ~s_reg.latch_a[ocl_pkg::BIT_STOP_EN]; // RULE11
    cfg.irq_pullup_enable        = ~s_reg.latch_b[ocl_pkg::BIT_IRQ_PUD]; // RULE13
    cfg.internal_osc_run_in_stop = ~s_reg.latch_b[ocl_pkg::BIT_OSC_OFF]; // RULE14
    cfg.crystal_select           = p_reg.osc_byte[ocl_pkg::BIT_OSC_SEL]; // RULE15
    cfg.crystal_output_pin_mode  = p_reg.osc_byte[ocl_pkg::BIT_OSC_SEL]; // RULE19
    cfg.port_a_bit_six_available = ~p_reg.osc_byte[ocl_pkg::BIT_OSC_SEL]; // RULE19
  end

endmodule // ocl_top

//--- shared/ocl_pkg.sv
// Constants and carrier types for the option configuration latches
// Contract
// RULE1: Each latch register accepts one write after reset, held until next reset.
// RULE2: Any reset clears both latch registers, except the brownout trip bits.
// RULE3: Latch registers sit at indexes 1E and 1F and read back anytime.
// RULE4: Brownout trip bits are writable once only after power-on reset.
// RULE5: Trip bits 4 and 3 clear on power-on reset only.
// RULE6: Watchdog rate select picks 2^13-2^4 or 2^18-2^4 oscillator cycles.
// RULE7: Brownout disable bit one disables the monitor, zero enables it.
// RULE8: Short stop recovery one gives 32 cycles, zero gives 4096.
// RULE9: Stop exit by reset always uses the 4096 cycle recovery.
// RULE10: Software keeps short stop recovery clear with a crystal clock.
// RULE11: Stop enable zero makes stop opcode illegal; one executes it.
// RULE12: Watchdog disable one disables watchdog; zero, the reset value, enables it.
// RULE13: Latch B bit 7 one disconnects the interrupt pin pull-up.
// RULE14: Latch B bit 0 one stops internal oscillator in stop mode.
// RULE15: Option byte bit 7 selects crystal when one, RC when zero.
// RULE16: Option byte is read after every power-on reset to pick oscillator.
// RULE17: Option byte cannot be changed by an ordinary bus write.
// RULE18: Software programs option byte bits 6 to 0 as ones.
// RULE19: With crystal selected the shared pin is crystal output only.
// RULE20: Further writes to a written latch are ignored silently.
package ocl_pkg;

  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  // Register indexes; byte address is four times the index
  localparam logic [5:0]  IDX_LATCH_B   = 6'h1E;
  localparam logic [5:0]  IDX_LATCH_A   = 6'h1F;
  localparam logic [5:0]  IDX_OSC_OPT   = 6'h20;
  // Latch A fields
  localparam int          BIT_WDG_RATE  = 7;
  localparam int          BIT_BO_DIS    = 4;
  localparam int          BIT_SHORT_STOP_RECOVERY     = 2;
  localparam int          BIT_STOP_EN   = 1;
  localparam int          BIT_WDG_DIS   = 0;
  localparam logic [7:0]  MASK_LATCH_A  = 8'h97;
  // Latch B fields
  localparam int          BIT_IRQ_PUD   = 7;
  localparam int          BIT_TRIP_HI   = 4;
  localparam int          BIT_TRIP_LO   = 3;
  localparam int          BIT_OSC_OFF   = 0;
  localparam logic [7:0]  MASK_LATCH_B  = 8'h81;
  // Option byte field
  localparam int          BIT_OSC_SEL   = 7;
  localparam logic [7:0]  RST_LATCH     = 8'h00;
  localparam logic [1:0]  RST_TRIP      = 2'h0;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  // Counts in internal oscillator cycles
  localparam logic [18:0] WDG_SHORT_CYC = 19'h01FF0;
  localparam logic [18:0] WDG_LONG_CYC  = 19'h3FFF0;
  localparam logic [12:0] REC_SHORT_CYC = 13'h0020;
  localparam logic [12:0] REC_LONG_CYC  = 13'h1000;

  typedef struct packed {
    logic        watchdog_enable;
    logic [18:0] watchdog_timeout_cycles;
    logic        brownout_enable;
    logic [1:0]  brownout_trip_sel;
    logic [12:0] stop_recovery_cycles;
    logic        stop_instr_enable;
    logic        stop_opcode_illegal;
    logic        irq_pullup_enable;
    logic        internal_osc_run_in_stop;
    logic        crystal_select;
    logic        crystal_output_pin_mode;
    logic        port_a_bit_six_available;
  } ocl_cfg_t;

  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
    logic [7:0] latch_a;
    logic [7:0] latch_b;
    logic       written_a;
    logic       written_b;
  } ocl_state_t;

  typedef struct packed {
    logic [1:0] trip;
    logic       trip_written;
    logic [7:0] osc_byte;
    logic       osc_loaded;
  } ocl_por_state_t;

endpackage

//--- sim/ocl_properties.sv
// Checker for the option latch bus timing and option outputs
`timescale 1ns/1ps
module ocl_properties
(
  // Clock and resets
  input wire logic                        clock,
  input wire logic                        rstn,
  input wire logic                        por_rstn,
  // Bus
  input wire logic [ocl_pkg::ADDR_W-1:0]  address,
  input wire logic                        read,
  input wire logic                        write,
  input wire logic [ocl_pkg::DATA_W-1:0]  writedata,
  input wire logic [3:0]                  byteenable,
  input wire logic [ocl_pkg::DATA_W-1:0]  readdata,
  input wire logic                        waitrequest,
  // System side
  input wire logic [7:0]                  nv_option_byte,
  input wire logic                        stop_exit_by_reset,
  input wire ocl_pkg::ocl_cfg_t           cfg
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  a_wait_first: assert property ($rose(read | write) |-> waitrequest) else $error("no wait cycle");
  a_one_wait: assert property ((read | write) && waitrequest |=> !waitrequest) else $error("late answer");
  a_read_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper bits set");
  a_wdg_hold: assert property ($changed(cfg.watchdog_enable) |-> $past(write && !waitrequest && address == 8'h7C))
    else $error("watchdog enable moved");
  a_irq_hold: assert property ($changed(cfg.irq_pullup_enable) |-> $past(write && !waitrequest && address == 8'h78))
    else $error("pull-up moved");
  a_trip_hold: assert property ($changed(cfg.brownout_trip_sel) |-> $past(write && !waitrequest && address == 8'h78))
    else $error("trip bits moved");
  a_rate_vals: assert property (cfg.watchdog_timeout_cycles inside {19'h01FF0, 19'h3FFF0})
    else $error("bad rate");
  a_rec_reset: assert property (stop_exit_by_reset |-> cfg.stop_recovery_cycles == 13'h1000)
    else $error("short rec");
  a_stop_pair: assert property (cfg.stop_instr_enable != cfg.stop_opcode_illegal)
    else $error("stop pair");
  a_xtal_pin: assert property (cfg.port_a_bit_six_available == !cfg.crystal_select)
    else $error("pin mode");
endmodule // ocl_properties
bind ocl_top ocl_properties u_ocl_properties (.clock, .rstn, .por_rstn, .address, .read, .write, .writedata,
  .byteenable, .readdata, .waitrequest, .nv_option_byte, .stop_exit_by_reset, .cfg);

//--- sim/option_config_latches_bench.sv
// Self-checking bench for the option configuration latches
`timescale 1ns/1ps
module option_config_latches_bench;
  logic        clock = 0, rstn = 0, por_rstn = 0, read = 0, write = 0, stop_exit_by_reset = 0, waitrequest;
  logic [7:0]  address = 8'h00, nv_option_byte = 8'hFF, a, b, opt;
  logic [3:0]  byteenable = 4'hF;
  logic [31:0] writedata = 32'h0, readdata, q;
  int          mismatches = 0, compares = 0, cycles = 0;
  ocl_pkg::ocl_cfg_t cfg;
  always #50 clock = ~clock;
  ocl_top u_ocl_top (.clock, .rstn, .por_rstn, .address, .read, .write, .writedata, .byteenable, .readdata,
    .waitrequest, .nv_option_byte, .stop_exit_by_reset, .cfg);
  task automatic close_out;
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Whole run is a few hundred cycles
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      mismatches++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] adr, input logic [7:0] d = 8'h00, input logic [3:0] be = 4'h1);
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= adr;
    writedata <= {24'h0, d};
    byteenable <= be;
    @(posedge clock);
    while (waitrequest !== 1'b0)
      @(posedge clock);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rst(input logic por);
    rstn <= 1'b0;
    por_rstn <= !por;
    repeat (3) @(posedge clock);
    rstn <= 1'b1;
    por_rstn <= 1'b1;
    @(posedge clock);
  endtask
  // Plain reset reopens bits 7 and 0 only
  function automatic logic [31:0] relatch_b(input logic [7:0] first, input logic [7:0] next);
    return {24'h0, (next & 8'h81) | (first & 8'h18)};
  endfunction
  initial
  begin
    void'($urandom(57226));
    for (int i = 0; i < 4; i++)
    begin
      opt = {i[1], 7'h7F};
      nv_option_byte <= opt;
      a = $urandom;
      b = $urandom;
      // Short recovery only with the RC clock
      a[2] = !opt[7];
      rst(1'b1);
      bus(0, 8'h80);
      check(q, {24'h0, nv_option_byte});
      check(cfg.crystal_select, nv_option_byte[7]);
      check({cfg.crystal_output_pin_mode, cfg.port_a_bit_six_available}, {opt[7], !opt[7]});
      bus(0, 8'h78);
      check(q, 32'h0);
      bus(1, 8'h7C, a, 4'h0);
      bus(1, 8'h7C, a);
      bus(1, 8'h7C, ~a);
      stop_exit_by_reset <= i[0];
      bus(0, 8'h7C);
      check(q, {24'h0, a & 8'h97});
      check({cfg.watchdog_enable, cfg.brownout_enable, cfg.stop_instr_enable}, {!a[0], !a[4], a[1]});
      check(cfg.stop_opcode_illegal, !a[1]);
      check(cfg.watchdog_timeout_cycles, a[7] ? 19'h01FF0 : 19'h3FFF0);
      check(cfg.stop_recovery_cycles, (a[2] && !i[0]) ? 13'h0020 : 13'h1000);
      bus(1, 8'h78, b);
      bus(1, 8'h80, b);
      bus(0, 8'h78);
      check(q, {24'h0, b & 8'h99});
      check({cfg.irq_pullup_enable, cfg.internal_osc_run_in_stop}, {!b[7], !b[0]});
      check(cfg.brownout_trip_sel, b[4:3]);
      bus(0, 8'h80);
      check(q, {24'h0, nv_option_byte});
      bus(0, 8'h40);
      check(q, 32'h0);
      rst(1'b0);
      bus(0, 8'h7C);
      check(q, 32'h0);
      check(cfg.crystal_select, opt[7]);
      bus(1, 8'h78, ~b);
      bus(0, 8'h78);
      check(q, relatch_b(b, ~b));
    end
    close_out();
  end
endmodule // option_config_latches_bench
